// file: core/pccl_config_bank.sv
// Configuration register bank: command/status, class/revision, latency/cache line, CSR base
// Notes on behaviour
// - 66 MHz capable bit always reads zero
// - New capability bit follows loaded EEPROM flag
// - SERR enable and parity response plus address parity error asserts SERR
// - Parity response set: signal fatal error on parity
// - Parity response clear: parity errors only set the detected parity error bit
// - Parity response bit resets to zero
// - Bus mastering only while master enable set
// - Memory cycles answered only while memory enable
// - Base class byte reads network controller code
// - Subclass zero, reserved byte below reads zero
// - Writable eight-bit latency timer in byte one
// - FRAME released early: timer disregarded
// - Expired timer: terminate once GNT deasserted
// - Writable eight-bit cache line size, byte zero
// - Status bits clear by writing one only
// - Command all zero: only configuration accesses answered
// - Software reset leaves configuration registers alone
`include "pccl_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module pccl_config_bank #(
    parameter logic [3:0] REVISION_NUM = 4'h3, // Arbitrary value
    parameter logic [3:0] STEP_NUM = 4'h5, // Arbitrary value
    parameter int LAT_WIDTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire pccl_pkg::pccl_cfg_req_t cfgReq,
    input wire pccl_pkg::pccl_evt_t busEvt,
    input wire logic newCapFlag,
    input wire logic softReset,
    input wire logic masterFrameStart,
    input wire logic masterFrameEnd,
    input wire logic gntActive,
    input wire logic memCycleHit,
    output logic [31:0] cfgRdData,
    output logic cfgRdValid,
    output logic masterEnable,
    output logic memRespondEnable,
    output logic memCycleClaim,
    output logic serrAssert,
    output logic fatalParErr,
    output logic latTerminate,
    output logic [7:0] cacheLineSize,
    output logic [31:0] csrBaseAddr
);
    import pccl_pkg::*;

    // Elaboration check: the timer and the read path assume eight bits
    if (LAT_WIDTH != 8)
    begin : g_lat_width_check
        $error("Latency timer field must be eight bits wide");
    end

    ////////////////////////////////////////////////////////////////////////
    // State
    logic [15:0] cmd_reg, cmd_next; // Command half
    logic [5:0] stat_reg, stat_next; // Sticky status, bits 24 and 27..31
    logic capFlag_reg, capFlag_next; // Loaded capability flag
    logic [LAT_WIDTH-1:0] lat_reg, lat_next; // Latency timer value
    logic [7:0] cls_reg, cls_next; // Cache line size
    logic [20:0] base_reg, base_next; // CSR base bits 31..11
    // Read path and one-cycle pulse outputs
    logic [31:0] rd_reg, rd_next; // Read data, stands until the next read
    logic rdv_reg, rdv_next; // Read valid pulse
    logic serr_reg, serr_next; // System error pulse
    logic fatal_reg, fatal_next; // Fatal parity pulse
    logic claim_reg, claim_next; // Memory claim pulse
    // Latency timer group
    pccl_lt_state_t lt_reg, lt_next; // Timer phase
    logic [LAT_WIDTH-1:0] ltCnt_reg, ltCnt_next; // Down counter
    logic term_reg, term_next; // Terminate request
    logic [31:0] wMask; // Byte enables spread to bits
    logic [31:0] wData; // Write data with idle lanes zeroed
    logic [31:0] statWord; // Command/status word as read

    ////////////////////////////////////////////////////////////////////////
    // Read value assembly
    always_comb
    begin
        // Byte enables widened so each lane masks only its own bits
        wMask = {{8{cfgReq.byteEn[3]}}, {8{cfgReq.byteEn[2]}}, {8{cfgReq.byteEn[1]}}, {8{cfgReq.byteEn[0]}}};
        wData = cfgReq.wrData & wMask;
        statWord = 32'h00000000; // Reserved bits stay zero
        statWord[`PCCL_BIT_DET_PERR] = stat_reg[5];
        statWord[`PCCL_BIT_SIG_SERR] = stat_reg[4];
        statWord[`PCCL_BIT_RCV_MABORT] = stat_reg[3];
        statWord[`PCCL_BIT_RCV_TABORT] = stat_reg[2];
        statWord[`PCCL_BIT_TGT_ABORT] = stat_reg[1];
        // Select timing is fixed, never written
        statWord[26:25] = `PCCL_DEVSEL_TIMING;
        statWord[`PCCL_BIT_DATA_PAR] = stat_reg[0];
        statWord[`PCCL_BIT_CAP66] = 1'b0;
        statWord[`PCCL_BIT_NEW_CAP] = capFlag_reg;
        statWord[15:0] = cmd_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file next state
    always_comb
    begin
        // Hold all state but the capability flag by default; pulses drop after one cycle
        cmd_next = cmd_reg;
        stat_next = stat_reg;
        capFlag_next = newCapFlag;
        lat_next = lat_reg;
        cls_next = cls_reg;
        base_next = base_reg;
        rd_next = rd_reg;
        rdv_next = 1'b0;
        serr_next = 1'b0;
        fatal_next = 1'b0;
        claim_next = 1'b0;
        // Soft reset is not looked at: only rst_b restores defaults
        if (cfgReq.wrEn)
        begin
            case (cfgReq.addr)
                `PCCL_OFS_CMD_STAT:
                begin
                    // Only bits 8, 6, 2, 1 are writable
                    cmd_next = (cmd_reg & ~wMask[15:0]) | (wData[15:0] & 16'h0146);
                    // Write one to clear
                    stat_next = stat_reg & ~{wData[31], wData[30], wData[29], wData[28], wData[27], wData[24]};
                end
                // Each field follows its own byte enable
                `PCCL_OFS_LAT_CLS:
                begin
                    if (cfgReq.byteEn[1])
                        lat_next = wData[15:8];
                    if (cfgReq.byteEn[0])
                        cls_next = wData[7:0];
                end
                `PCCL_OFS_CSR_BASE:
                begin
                    // Bits 10..0 read zero; memory indicator fixed
                    base_next = (base_reg & ~wMask[31:11]) | wData[31:11];
                end
                default:
                begin
                    // Class/revision and unmapped writes are discarded
                end
            endcase
        end
        // Hardware events set after any clear, so the set wins
        // Any parity error is recorded, even with the response off
        if (busEvt.addrParErr || busEvt.dataParErr)
            stat_next[5] = 1'b1;
        // Address parity needs both enables to raise the system error
        if (busEvt.addrParErr && cmd_reg[`PCCL_BIT_SERR_EN] && cmd_reg[`PCCL_BIT_PAR_RESP])
        begin
            serr_next = 1'b1;
            stat_next[4] = 1'b1;
        end
        // With the response off a parity error leaves operation alone
        if ((busEvt.addrParErr || busEvt.dataParErr) && cmd_reg[`PCCL_BIT_PAR_RESP])
            fatal_next = 1'b1;
        // Data parity report only counts with the response on
        if (busEvt.dataParReport && cmd_reg[`PCCL_BIT_PAR_RESP])
            stat_next[0] = 1'b1;
        // Abort outcomes of target and master cycles
        if (busEvt.targetAbort)
            stat_next[1] = 1'b1;
        if (busEvt.rcvTargetAbort)
            stat_next[2] = 1'b1;
        if (busEvt.rcvMasterAbort)
            stat_next[3] = 1'b1;
        // Memory claims gated by enable; zero command drops all but config
        claim_next = memCycleHit && cmd_reg[`PCCL_BIT_MEM_EN];
        // A read answers one cycle after it is taken; old value if written at once
        if (cfgReq.rdEn)
        begin
            rdv_next = 1'b1;
            case (cfgReq.addr)
                `PCCL_OFS_CMD_STAT: rd_next = statWord;
                `PCCL_OFS_CLASS_REV: rd_next = {`PCCL_BASE_CLASS, `PCCL_SUB_CLASS, 8'h00, REVISION_NUM, STEP_NUM};
                `PCCL_OFS_LAT_CLS: rd_next = {16'h0000, lat_reg, cls_reg};
                `PCCL_OFS_CSR_BASE: rd_next = {base_reg, 11'h000};
                default: rd_next = 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Latency timer: runs per master frame
    always_comb
    begin
        lt_next = lt_reg;
        ltCnt_next = ltCnt_reg;
        // Terminate request is judged afresh each cycle
        term_next = 1'b0;
        case (lt_reg)
            // Waits for our own frame while mastering is allowed
            LT_IDLE:
            begin
                if (masterFrameStart && cmd_reg[`PCCL_BIT_MASTER_EN])
                begin
                    lt_next = (lat_reg == 8'h00) ? LT_EXPIRED : LT_COUNT;
                    ltCnt_next = lat_reg;
                end
            end
            // One count per bus clock; a count of one is the last
            LT_COUNT:
            begin
                if (masterFrameEnd)
                    lt_next = LT_IDLE;
                else if (ltCnt_reg <= 8'h01)
                    lt_next = LT_EXPIRED;
                else
                    ltCnt_next = ltCnt_reg - 8'h01;
            end
            // Holds until our frame ends; a zero setting lands here at once
            LT_EXPIRED:
            begin
                if (masterFrameEnd)
                    lt_next = LT_IDLE;
                else
                    term_next = !gntActive;
            end
            default: lt_next = LT_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file flops
    // Only the hardware reset reaches these; a soft reset never does
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            // Defaults of a hardware reset
            cmd_reg <= `PCCL_RST_CMD;
            stat_reg <= 6'h00;
            capFlag_reg <= 1'b0;
            lat_reg <= `PCCL_RST_LAT;
            cls_reg <= `PCCL_RST_CLS;
            base_reg <= `PCCL_RST_BASE;
            rd_reg <= 32'h00000000;
            rdv_reg <= 1'b0;
            serr_reg <= 1'b0;
            fatal_reg <= 1'b0;
            claim_reg <= 1'b0;
        end
        else
        begin
            cmd_reg <= cmd_next;
            stat_reg <= stat_next;
            capFlag_reg <= capFlag_next;
            lat_reg <= lat_next;
            cls_reg <= cls_next;
            base_reg <= base_next;
            rd_reg <= rd_next;
            rdv_reg <= rdv_next;
            serr_reg <= serr_next;
            fatal_reg <= fatal_next;
            claim_reg <= claim_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Latency timer flops
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            // No frame in flight after reset
            lt_reg <= LT_IDLE;
            ltCnt_reg <= 8'h00;
            term_reg <= 1'b0;
        end
        else
        begin
            lt_reg <= lt_next;
            ltCnt_reg <= ltCnt_next;
            term_reg <= term_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all from flip-flops
    // Command bits leave as levels, the rest as registered values
    assign cfgRdData = rd_reg;
    assign cfgRdValid = rdv_reg;
    assign masterEnable = cmd_reg[`PCCL_BIT_MASTER_EN];
    assign memRespondEnable = cmd_reg[`PCCL_BIT_MEM_EN];
    assign memCycleClaim = claim_reg;
    assign serrAssert = serr_reg;
    assign fatalParErr = fatal_reg;
    assign latTerminate = term_reg;
    assign cacheLineSize = cls_reg;
    assign csrBaseAddr = {base_reg, 11'h000};
endmodule
`default_nettype wire

// file: shared/pccl_defs.svh
// Offsets, field positions, reset values and fixed codes of the configuration register bank
`ifndef PCCL_DEFS_SVH
`define PCCL_DEFS_SVH
`define PCCL_OFS_CMD_STAT 6'h04
`define PCCL_OFS_CLASS_REV 6'h08
`define PCCL_OFS_LAT_CLS 6'h0C
`define PCCL_OFS_CSR_BASE 6'h10
`define PCCL_BIT_MEM_EN 1
`define PCCL_BIT_MASTER_EN 2
`define PCCL_BIT_PAR_RESP 6
`define PCCL_BIT_SERR_EN 8
`define PCCL_BIT_NEW_CAP 20
`define PCCL_BIT_CAP66 21
`define PCCL_BIT_DATA_PAR 24
`define PCCL_BIT_TGT_ABORT 27
`define PCCL_BIT_RCV_TABORT 28
`define PCCL_BIT_RCV_MABORT 29
`define PCCL_BIT_SIG_SERR 30
`define PCCL_BIT_DET_PERR 31
`define PCCL_DEVSEL_TIMING 2'h1
`define PCCL_BASE_CLASS 8'h02
`define PCCL_SUB_CLASS 8'h00
`define PCCL_RST_CMD 16'h0000
`define PCCL_RST_LAT 8'h00
`define PCCL_RST_CLS 8'h00
`define PCCL_RST_BASE 21'h000000
`define PCCL_BASE_LSB 11
`endif

// file: shared/pccl_pkg.sv
// Types shared by the configuration register bank
package pccl_pkg;
    // One configuration access from the bus target logic
    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [5:0] addr;
        logic [3:0] byteEn;
        logic [31:0] wrData;
    } pccl_cfg_req_t;
    // Bus events that set sticky status bits
    typedef struct packed {
        logic addrParErr;
        logic dataParErr;
        logic dataParReport;
        logic targetAbort;
        logic rcvTargetAbort;
        logic rcvMasterAbort;
    } pccl_evt_t;
    // Latency timer state
    typedef enum logic [1:0] {LT_IDLE, LT_COUNT, LT_EXPIRED} pccl_lt_state_t;
endpackage

// file: dv/pccl_config_bank_assertions.sv
// Port checks for the configuration bank
`timescale 1ns/1ns
`default_nettype none
module pccl_config_bank_assertions (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire pccl_pkg::pccl_cfg_req_t cfgReq,
    input wire pccl_pkg::pccl_evt_t busEvt,
    input wire logic gntActive,
    input wire logic memCycleHit,
    input wire logic [31:0] cfgRdData,
    input wire logic cfgRdValid,
    input wire logic masterEnable,
    input wire logic memRespondEnable,
    input wire logic memCycleClaim,
    input wire logic serrAssert,
    input wire logic fatalParErr,
    input wire logic latTerminate
);
    import pccl_pkg::*;
    // Single clock domain
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    ////////////////////
    property p_claim; memCycleHit |=> memCycleClaim == $past(memRespondEnable); endproperty
    a_claim: assert property (p_claim) else $error("claim wrong");
    property p_serr; serrAssert |-> fatalParErr && $past(busEvt.addrParErr); endproperty
    a_serr: assert property (p_serr) else $error("serr wrong");
    property p_fatal; fatalParErr |-> $past(busEvt.addrParErr || busEvt.dataParErr); endproperty
    a_fatal: assert property (p_fatal) else $error("fatal wrong");
    property p_rdv; cfgReq.rdEn |=> cfgRdValid; endproperty
    a_rdv: assert property (p_rdv) else $error("no read valid");
    property p_norv; !cfgReq.rdEn |=> !cfgRdValid; endproperty
    a_norv: assert property (p_norv) else $error("stray valid");
    // Speed bit low and select timing fixed; bit 24 is a live status bit
    property p_stat;
        cfgRdValid && $past(cfgReq.addr) == 6'h04 |-> cfgRdData[26:25] == 2'h1 && cfgRdData[23:21] == 3'h0;
    endproperty
    a_stat: assert property (p_stat) else $error("status fixed bits");
    property p_class; cfgRdValid && $past(cfgReq.addr) == 6'h08 |-> cfgRdData[31:8] == 24'h020000; endproperty
    a_class: assert property (p_class) else $error("class wrong");
    property p_lat; latTerminate |-> masterEnable && !$past(gntActive); endproperty
    a_lat: assert property (p_lat) else $error("terminate wrong");
    property p_gnt; gntActive |=> !latTerminate; endproperty
    a_gnt: assert property (p_gnt) else $error("terminate under grant");
    // Main scenarios reached
    c_rd: cover property (cfgRdValid);
    c_serr: cover property (serrAssert);
    c_lat: cover property (latTerminate);
endmodule
`default_nettype wire

// file: dv/pccl_host_model.sv
// Configuration software side issuing register accesses
`timescale 1ns/1ns
`default_nettype none
module pccl_host_model (
    input wire logic sys_clk,
    input wire logic [31:0] cfgRdData,
    output var pccl_pkg::pccl_cfg_req_t cfgReq
);
    import pccl_pkg::*;
    // Bus idle from time zero
    initial cfgReq = '0;
    ////////////////////
    // Request held one cycle, taken at the next edge
    task automatic cfg_write(input logic [5:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge sys_clk);
        #1;
        cfgReq = '{1'b1, 1'b0, a, be, d};
        @(posedge sys_clk);
        #1;
        cfgReq = '0;
    endtask
    // Data captured after the taking edge, when valid stands
    task automatic cfg_read(input logic [5:0] a, output logic [31:0] q);
        @(posedge sys_clk);
        #1;
        cfgReq = '{1'b0, 1'b1, a, 4'hF, 32'h0};
        @(posedge sys_clk);
        #1;
        cfgReq = '0;
        q = cfgRdData;
    endtask
endmodule
`default_nettype wire

// file: dv/pccl_config_bank_tb.sv
// Self-checking bench for the configuration bank
`timescale 1ns/1ns
`default_nettype none
module pccl_config_bank_tb;
    import pccl_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    pccl_cfg_req_t cfgReq;
    pccl_evt_t busEvt = '0;
    logic newCapFlag = 1'b1, softReset = 1'b0, gntActive = 1'b0, memCycleHit = 1'b0;
    logic masterFrameStart = 1'b0, masterFrameEnd = 1'b0;
    logic [31:0] cfgRdData, csrBaseAddr;
    logic [7:0] cacheLineSize;
    logic cfgRdValid, masterEnable, memRespondEnable, memCycleClaim, serrAssert, fatalParErr, latTerminate;
    int errors = 0;
    int checks = 0;
    ////////////////////
    pccl_config_bank uut (.sys_clk, .rst_b, .cfgReq, .busEvt, .newCapFlag, .softReset, .masterFrameStart,
        .masterFrameEnd, .gntActive, .memCycleHit, .cfgRdData, .cfgRdValid, .masterEnable, .memRespondEnable,
        .memCycleClaim, .serrAssert, .fatalParErr, .latTerminate, .cacheLineSize, .csrBaseAddr);
    pccl_host_model host (.sys_clk, .cfgRdData, .cfgReq);
    // 100 MHz clock
    initial
        forever #5 sys_clk = ~sys_clk;
    ////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] q;
        host.cfg_read(a, q);
        chk(q, exp);
    endtask
    // Inputs move 1 ns after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic evt(input pccl_evt_t e);
        busEvt = e;
        tick(1);
        busEvt = '0;
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    ////////////////////
    // Main sequence
    initial
    begin
        tick(6);
        rst_b = 1'b1;
        rd(6'h04, 32'h02100000);
        rd(6'h08, 32'h02000035);
        rd(6'h0C, 32'h0);
        rd(6'h14, 32'h0);
        host.cfg_write(6'h04, 4'hF, 32'hFFFFFFFF);
        rd(6'h04, 32'h02100146);
        chk({masterEnable, memRespondEnable}, 32'h3);
        host.cfg_write(6'h08, 4'hF, 32'hFFFFFFFF);
        rd(6'h08, 32'h02000035);
        host.cfg_write(6'h0C, 4'hF, 32'hFFFFFFFF);
        rd(6'h0C, 32'h0000FFFF);
        chk(cacheLineSize, 32'hFF);
        host.cfg_write(6'h10, 4'hF, 32'hFFFFFFFF);
        rd(6'h10, 32'hFFFFF800);
        chk(csrBaseAddr, 32'hFFFFF800);
        host.cfg_write(6'h0C, 4'h3, 32'h00000300);
        evt(6'h20);
        chk({serrAssert, fatalParErr}, 32'h3);
        rd(6'h04, 32'hC2100146);
        host.cfg_write(6'h04, 4'h8, 32'h80000000);
        rd(6'h04, 32'h42100146);
        softReset = 1'b1;
        rd(6'h0C, 32'h00000300);
        softReset = 1'b0;
        memCycleHit = 1'b1;
        tick(1);
        memCycleHit = 1'b0;
        chk(memCycleClaim, 32'h1);
        // Frame dropped before expiry, grant already gone
        masterFrameStart = 1'b1;
        tick(1);
        masterFrameStart = 1'b0;
        masterFrameEnd = 1'b1;
        tick(1);
        masterFrameEnd = 1'b0;
        tick(5);
        chk(latTerminate, 32'h0);
        gntActive = 1'b1;
        masterFrameStart = 1'b1;
        tick(1);
        masterFrameStart = 1'b0;
        tick(6);
        chk(latTerminate, 32'h0);
        gntActive = 1'b0;
        tick(2);
        chk(latTerminate, 32'h1);
        masterFrameEnd = 1'b1;
        tick(1);
        masterFrameEnd = 1'b0;
        host.cfg_write(6'h04, 4'h3, 32'h0);
        memCycleHit = 1'b1;
        tick(1);
        memCycleHit = 1'b0;
        chk({masterEnable, memCycleClaim}, 32'h0);
        evt(6'h20);
        chk({serrAssert, fatalParErr}, 32'h0);
        // Data parity and abort events with the response back on
        host.cfg_write(6'h04, 4'h3, 32'h00000146);
        evt(6'h1F);
        chk({serrAssert, fatalParErr}, 32'h1);
        rd(6'h04, 32'hFB100146);
        // Hardware reset in mid-run with the capability flag dropped
        newCapFlag = 1'b0;
        rst_b = 1'b0;
        tick(2);
        rst_b = 1'b1;
        rd(6'h04, 32'h02000000);
        rd(6'h0C, 32'h0);
        chk({masterEnable, memRespondEnable}, 32'h0);
        end_sim();
    end
    // Watchdog well beyond the run length
    initial
    begin
        #20000;
        errors++;
        end_sim();
    end
endmodule
bind pccl_config_bank pccl_config_bank_assertions chk_i (.sys_clk, .rst_b, .cfgReq, .busEvt, .gntActive,
    .memCycleHit, .cfgRdData, .cfgRdValid, .masterEnable, .memRespondEnable, .memCycleClaim, .serrAssert,
    .fatalParErr, .latTerminate);
`default_nettype wire
